// >>> rtl/channel_command_interface.sv
// channel command front end: data registers, command register, channel database
// assumes an upstream slave decoder gives one-cycle read/write strobes with byte address
//
// How it works
// - command copies data registers into channel entry
// - completion raises ack or fail vector
// - other channels stay untouched during a command
// - data registers keep contents across commands, except a debug readback that loads them from the channel entry
// - transmit command code is one-hot, seven codes
// - receive command code is one-hot, five codes
// - channel select picks one of 256 channels
`timescale 1ns/1ps

module channel_command_interface
	import channel_select_cmd_pkg::*;
#(
	parameter int DATA_WORDS = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWdata,
	output logic [31:0] regRdata,
	output cmd_vector_t cmdVector,
	output logic cfgWrite,
	output logic [CHANNEL_SELECT_W-1:0] cfgChan,
	output logic [DATA_WORDS*32-1:0] cfgData,
	output logic [NUM_CHANNELS-1:0] txOn,
	output logic [NUM_CHANNELS-1:0] rxOn
);

	localparam int DW = DATA_WORDS * 32;
	localparam logic [4:0] INIT_CYC = 5'(INIT_LATENCY);
	localparam logic [4:0] OTHER_CYC = 5'(OTHER_LATENCY);

	// a code is legal when zero or exactly one bit set
	function automatic logic legal_code(input logic [6:0] code);
		legal_code = (code & (code - 7'h01)) == 7'h00;
	endfunction

	// byte address of data word i
	function automatic logic [11:0] data_offs(input int i);
		data_offs = DATA_BASE_OFFS + 12'(i) * WORD_STEP;
	endfunction

	logic [31:0] dataRegs_q [DATA_WORDS];
	logic [DW-1:0] chanDb [NUM_CHANNELS];
	logic [31:0] command_q;
	channel_select_cmd_t cmd_q;
	cmd_state_t state_q, state_d;
	logic [4:0] wait_q;
	logic fail_q;
	cmd_vector_t vector_q;
	logic cfgWrite_q;
	logic [DW-1:0] cfgData_q;
	logic [NUM_CHANNELS-1:0] txOn_q, rxOn_q;
	logic [31:0] rdata_q;

	// decode of the slave access
	wire logic cmdHit = regAddr == CHANNEL_COMMAND_OFFS;
	wire logic idle = state_q == ST_IDLE || state_q == ST_REPORT; // report cycle takes commands
	wire logic cmdStrobe = regWrite && cmdHit && idle;
	wire logic busyStrobe = regWrite && cmdHit && !idle;
	wire logic [TXCMD_W-1:0] newTx = regWdata[TXCMD_LSB +: TXCMD_W];
	wire logic [RXCMD_W-1:0] newRx = regWdata[RXCMD_LSB +: RXCMD_W];
	wire logic [CHANNEL_SELECT_W-1:0] newChan = regWdata[CHANNEL_SELECT_LSB +: CHANNEL_SELECT_W];
	wire logic isDebug = cmd_q.txCode == TX_DEBUG || cmd_q.rxCode == RX_DEBUG;
	wire logic isInit = cmd_q.txCode == TX_INIT || cmd_q.rxCode == RX_INIT;
	wire logic [DW-1:0] dataFlat;

	// the data registers flattened as one database entry
	genvar g;
	generate
		for (g = 0; g < DATA_WORDS; g++) begin : g_flat
			assign dataFlat[g*32 +: 32] = dataRegs_q[g];
		end
	endgenerate

	// command sequencer state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cmdStrobe) begin
					state_d = ST_COPY;
				end
			end
			ST_COPY: state_d = ST_WAIT;
			ST_WAIT: begin
				if (wait_q == 5'h00) begin
					state_d = ST_REPORT;
				end
			end
			ST_REPORT: begin
				// a refusal here would collide with the report vector and be lost
				state_d = cmdStrobe ? ST_COPY : ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// sequencer registers, latency count and failure judgement
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			command_q <= CHANNEL_COMMAND_RESET;
			cmd_q <= '0;
			wait_q <= '0;
			fail_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (cmdStrobe) begin
				command_q <= regWdata;
				cmd_q <= '{txCode: newTx, rxCode: newRx, channel_select: newChan};
				fail_q <= !legal_code(newTx) || !legal_code({2'b00, newRx})
					|| (newTx == TX_INIT && txOn_q[newChan]);
			end
			if (state_q == ST_COPY) begin
				// reconfiguration time depends on the command
				wait_q <= isInit ? INIT_CYC : OTHER_CYC;
			end else if (wait_q != 5'h00) begin
				wait_q <= wait_q - 5'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (state_q == ST_COPY && !fail_q && !isDebug) begin
			chanDb[cmd_q.channel_select] <= dataFlat;
		end
	end

	// data registers; only reset, software writes or a debug readback change them
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int i = 0; i < DATA_WORDS; i++) begin
				dataRegs_q[i] <= DATA_RESET;
			end
		end else begin
			for (int i = 0; i < DATA_WORDS; i++) begin
				if (state_q == ST_COPY && !fail_q && isDebug) begin
					dataRegs_q[i] <= chanDb[cmd_q.channel_select][i*32 +: 32];
				end else if (regWrite && regAddr == data_offs(i)) begin
					dataRegs_q[i] <= regWdata;
				end
			end
		end
	end

	// per-channel direction state and configuration strobe
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			txOn_q <= '0;
			rxOn_q <= '0;
			cfgWrite_q <= 1'b0;
			cfgData_q <= '0;
		end else begin
			cfgWrite_q <= state_q == ST_COPY && !fail_q && !isDebug;
			if (state_q == ST_COPY && !fail_q) begin
				cfgData_q <= dataFlat;
				if (cmd_q.txCode == TX_INIT) begin
					txOn_q[cmd_q.channel_select] <= 1'b1;
				end else if (cmd_q.txCode == TX_OFF) begin
					txOn_q[cmd_q.channel_select] <= 1'b0;
				end
				if (cmd_q.rxCode == RX_INIT) begin
					rxOn_q[cmd_q.channel_select] <= 1'b1;
				end else if (cmd_q.rxCode == RX_OFF) begin
					rxOn_q[cmd_q.channel_select] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			vector_q <= '0;
		end else if (state_q == ST_REPORT) begin
			vector_q <= '{valid: 1'b1, fail: fail_q, txCode: cmd_q.txCode,
				rxCode: cmd_q.rxCode, channel_select: cmd_q.channel_select};
		end else if (busyStrobe) begin
			vector_q <= '{valid: 1'b1, fail: 1'b1, txCode: newTx,
				rxCode: newRx, channel_select: newChan};
		end else begin
			vector_q.valid <= 1'b0;
		end
	end

	// read data, registered one cycle after the read strobe
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (regRead) begin
			rdata_q <= '0;
			if (cmdHit) begin
				rdata_q <= command_q;
				rdata_q[BUSY_BIT] <= !idle;
			end
			for (int i = 0; i < DATA_WORDS; i++) begin
				if (regAddr == data_offs(i)) begin
					rdata_q <= dataRegs_q[i];
				end
			end
		end
	end

	assign regRdata = rdata_q;
	assign cmdVector = vector_q;
	assign cfgWrite = cfgWrite_q;
	assign cfgChan = cmd_q.channel_select;
	assign cfgData = cfgData_q;
	assign txOn = txOn_q;
	assign rxOn = rxOn_q;

endmodule // channel_command_interface

// >>> rtl/channel_select_cmd_pkg.sv
// channel command front end: register map, command word layout, codes, types
// assumes a 32-bit decoded slave register port and the device clock
package channel_select_cmd_pkg;

	// register byte offsets
	localparam logic [11:0] CHANNEL_COMMAND_OFFS = 12'h000;
	localparam logic [11:0] DATA_BASE_OFFS = 12'h004;
	localparam logic [11:0] WORD_STEP = 12'h004;
	localparam logic [31:0] CHANNEL_COMMAND_RESET = 32'h00000000;
	localparam logic [31:0] DATA_RESET = 32'h00000000;

	// command word layout
	localparam int CHANNEL_SELECT_LSB = 0;
	localparam int CHANNEL_SELECT_W = 8;
	localparam int RXCMD_LSB = 16;
	localparam int RXCMD_W = 5;
	localparam int TXCMD_LSB = 24;
	localparam int TXCMD_W = 7;
	localparam int BUSY_BIT = 31;
	localparam int NUM_CHANNELS = 256;

	// transmit command codes, one-hot
	localparam logic [6:0] TX_INIT = 7'h01;
	localparam logic [6:0] TX_OFF = 7'h02;
	localparam logic [6:0] TX_ABORT = 7'h04;
	localparam logic [6:0] TX_HOLD_RESET = 7'h08;
	localparam logic [6:0] TX_DEBUG = 7'h10;
	localparam logic [6:0] TX_IDLE = 7'h20;
	localparam logic [6:0] TX_UPDATE = 7'h40;
	localparam logic [6:0] TX_NONE = 7'h00;

	// receive command codes, one-hot
	localparam logic [4:0] RX_INIT = 5'h01;
	localparam logic [4:0] RX_OFF = 5'h02;
	localparam logic [4:0] RX_ABORT = 5'h04;
	localparam logic [4:0] RX_HOLD_RESET = 5'h08;
	localparam logic [4:0] RX_DEBUG = 5'h10;
	localparam logic [4:0] RX_NONE = 5'h00;

	// reconfiguration latencies in core clock cycles
	localparam int INIT_LATENCY = 16;
	localparam int OTHER_LATENCY = 4;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_COPY = 2'b01,
		ST_WAIT = 2'b10,
		ST_REPORT = 2'b11
	} cmd_state_t;

	// decoded channel command
	typedef struct packed {
		logic [TXCMD_W-1:0] txCode;
		logic [RXCMD_W-1:0] rxCode;
		logic [CHANNEL_SELECT_W-1:0] channel_select;
	} channel_select_cmd_t;

	// completion vector towards the interrupt logic
	typedef struct packed {
		logic valid;
		logic fail;
		logic [TXCMD_W-1:0] txCode;
		logic [RXCMD_W-1:0] rxCode;
		logic [CHANNEL_SELECT_W-1:0] channel_select;
	} cmd_vector_t;

endpackage

// >>> tb/channel_select_cmd_sva.sv
// assertions on the channel command front end ports
// assumes a bind onto channel_command_interface
`timescale 1ns/1ps
module channel_select_cmd_sva
	import channel_select_cmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic regWrite,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire cmd_vector_t cmdVector,
	input wire logic cfgWrite,
	input wire logic [CHANNEL_SELECT_W-1:0] cfgChan,
	input wire logic [NUM_CHANNELS-1:0] txOn,
	input wire logic [NUM_CHANNELS-1:0] rxOn
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// a coded command write, and its report
	sequence sCmd;
		regWrite && regAddr == 12'h000 && |regWdata[30:16];
	endsequence
	sequence sAck;
		cmdVector.valid && !cmdVector.fail && cmdVector.channel_select == $past(cfgChan);
	endsequence
	chk_vec_follows: assert property (sCmd |-> ##[1:21] cmdVector.valid)
		else $error("no vector after command");
	chk_ack_after: assert property (cfgWrite |-> ##[1:20] sAck)
		else $error("no ack after reconfigure");
	chk_cfg_cause: assert property (cfgWrite |-> $past(regWrite, 2) && $past(regAddr, 2) == 12'h000)
		else $error("reconfigure without command");
	chk_channel_select_match: assert property (cfgWrite |-> cfgChan == $past(regWdata[7:0], 2))
		else $error("wrong channel reconfigured");
	chk_tx_onehot: assert property (cmdVector.valid && !cmdVector.fail |-> $onehot0(cmdVector.txCode))
		else $error("ack for bad transmit code");
	chk_rx_onehot: assert property (cmdVector.valid && !cmdVector.fail |-> $onehot0(cmdVector.rxCode))
		else $error("ack for bad receive code");
	chk_others_kept: assert property (cfgWrite |-> (((txOn ^ $past(txOn)) | (rxOn ^ $past(rxOn)))
		& ~(256'h1 << cfgChan)) == '0)
		else $error("other channel disturbed");
	chk_on_stable: assert property (!cfgWrite |-> $stable(txOn) && $stable(rxOn))
		else $error("channel state moved idle");
	chk_zero_keeps: assert property (cfgWrite && $past(regWdata[30:24], 2) == 7'h00 |-> txOn == $past(txOn))
		else $error("zero code changed transmit");
endmodule // channel_select_cmd_sva

bind channel_command_interface channel_select_cmd_sva chk_u (.core_clk, .nrst, .regWrite, .regAddr,
	.regWdata, .cmdVector, .cfgWrite, .cfgChan, .txOn, .rxOn);

// >>> tb/tb_channel_command_interface.sv
// self-checking bench for the channel command front end
// assumes the design package and the bound checker are compiled first
`timescale 1ns/1ps
module tb_channel_command_interface
	import channel_select_cmd_pkg::*;
;
	typedef struct {logic [31:0] cmd; logic [2:0] f;} row_t; // f = txOn, rxOn, fail
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [31:0] regWdata = 32'h00000000;
	logic [31:0] regRdata;
	cmd_vector_t cmdVector;
	logic [127:0] cfgData;
	logic cfgWrite;
	logic [CHANNEL_SELECT_W-1:0] cfgChan;
	logic [NUM_CHANNELS-1:0] txOn;
	logic [NUM_CHANNELS-1:0] rxOn;
	int errTotal = 0;
	int checksDone = 0;
	int cfgCount = 0;
	int c0 = 0;
	// repeat init of channel 0 refused
	// init, repeat init, bad codes, off, then every other code except the debug codes
	row_t rows [10] = '{'{32'h01010000, 3'h6}, '{32'h010000ff, 3'h4}, '{32'h01000000, 3'h7},
		'{32'h03000000, 3'h7}, '{32'h00030000, 3'h7}, '{32'h02020000, 3'h0},
		'{32'h20080007, 3'h0}, '{32'h40040007, 3'h0}, '{32'h08000007, 3'h0},
		'{32'h04000005, 3'h0}};
	always #50 core_clk = ~core_clk;
	// counts reconfigure pulses; each stands between two rising edges
	always @(negedge core_clk) begin
		if (cfgWrite === 1'b1)
			cfgCount <= cfgCount + 1;
	end
	channel_command_interface dut_u (.core_clk(core_clk), .nrst(nrst), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.cmdVector(cmdVector), .cfgWrite(cfgWrite), .cfgChan(cfgChan), .cfgData(cfgData),
		.txOn(txOn), .rxOn(rxOn));
	task stopTest;
		if (errTotal == 0 && checksDone > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checksDone++;
		if (g !== e) begin
			errTotal++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge core_clk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge core_clk);
		regWrite = 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input string n);
		@(negedge core_clk);
		regRead = 1'b1;
		regAddr = a;
		@(negedge core_clk);
		regRead = 1'b0;
		chk(n, e, regRdata);
	endtask
	// bounded wait for the completion pulse
	task waitVec;
		for (int k = 0; k < 40; k++) begin
			@(negedge core_clk);
			if (cmdVector.valid === 1'b1)
				return;
		end
		chk("vector", 32'h1, 32'h0);
		stopTest;
	endtask
	initial begin
		repeat (10) @(negedge core_clk);
		nrst = 1'b1;
		rd(12'h000, 32'h00000000, "resetCmd");
		for (int i = 0; i < 10; i++) begin
			wr(12'h004, 32'ha5000000 | i);
			c0 = cfgCount;
			wr(12'h000, rows[i].cmd);
			waitVec;
			chk("cfgWrite", 32'(!rows[i].f[0]), 32'(cfgCount - c0));
			chk("cfgChan", 32'(rows[i].cmd[7:0]), 32'(cfgChan));
			chk("fail", 32'(rows[i].f[0]), 32'(cmdVector.fail));
			chk("channel_select", 32'(rows[i].cmd[7:0]), 32'(cmdVector.channel_select));
			chk("txOn", 32'(rows[i].f[2]), 32'(txOn[rows[i].cmd[7:0]]));
			chk("rxOn", 32'(rows[i].f[1]), 32'(rxOn[rows[i].cmd[7:0]]));
			if (!rows[i].f[0])
				chk("cfgData", 32'ha5000000 | i, cfgData[31:0]);
		end
		rd(12'h004, 32'ha5000009, "dataKeep");
		rd(12'hffc, 32'h00000000, "unmapped");
		c0 = cfgCount;
		wr(12'h000, 32'h00100000);
		waitVec;
		chk("dbgCfg", 32'h0, 32'(cfgCount - c0));
		rd(12'h004, 32'ha5000005, "debugCopy");
		wr(12'h004, 32'ha5000010);
		wr(12'h000, 32'h02000005);
		wr(12'h000, 32'h02000006);
		chk("busyVec", 32'h1, 32'(cmdVector.valid));
		chk("busyFail", 32'h1, 32'(cmdVector.fail));
		chk("busyChan", 32'h6, 32'(cmdVector.channel_select));
		waitVec;
		chk("ackChan", 32'h5, 32'(cmdVector.channel_select));
		chk("ackFail", 32'h0, 32'(cmdVector.fail));
		chk("farChan", 32'h1, 32'(txOn[255]));
		wr(12'h000, 32'h00010003);
		rd(12'h000, 32'h80010003, "busyRead");
		waitVec;
		chk("rxInit", 32'h1, 32'(rxOn[3]));
		rd(12'h000, 32'h00010003, "idleRead");
		// mid-run reset, held over three rising edges
		@(negedge core_clk);
		nrst = 1'b0;
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		chk("rstTx", 32'h0, 32'(txOn[255]));
		chk("rstRx", 32'h0, 32'(rxOn[3]));
		chk("rstVec", 32'h0, 32'(cmdVector.valid));
		rd(12'h004, 32'h00000000, "rstData");
		wr(12'h004, 32'h5a000001);
		wr(12'h000, 32'h010000ff);
		waitVec;
		chk("reInit", 32'h0, 32'(cmdVector.fail));
		chk("reTxOn", 32'h1, 32'(txOn[255]));
		chk("reCfg", 32'h5a000001, cfgData[31:0]);
		stopTest;
	end
endmodule // tb_channel_command_interface
